// [lasr_defs.vh]
// Constants for the linear array scan readout block
`ifndef LASR_DEFS_VH
`define LASR_DEFS_VH
`define LASR_NUM_PIXELS      11'h0_200
`define LASR_PIX_IDX_W       10
`define LASR_SAMPLE_W        12
`define LASR_RESET_LEVEL     12'h0_800
`define LASR_PIX_WIDTH_NS    200
`define LASR_CLK_PERIOD_NS   10
`define LASR_MIN_HIGH_CYC    ((`LASR_PIX_WIDTH_NS + `LASR_CLK_PERIOD_NS - 1) / `LASR_CLK_PERIOD_NS)
`endif

// [lasr_pixel_mem.v]
// Pixel charge store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "lasr_defs.vh"
module lasr_pixel_mem (
  input  wire                         sys_clk,
  input  wire                         wr_en,
  input  wire [`LASR_PIX_IDX_W-1:0]   wr_addr,
  input  wire [`LASR_SAMPLE_W-1:0]    wr_data,
  input  wire [`LASR_PIX_IDX_W-1:0]   rd_addr,
  output reg  [`LASR_SAMPLE_W-1:0]    rd_data
);
  reg [`LASR_SAMPLE_W-1:0] mem [0:(1<<`LASR_PIX_IDX_W)-1];
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [lasr_scan_readout.v]
// Linear photodiode array scan and readout, device side
// What this block, its controller and the bench do
// [R1] Video sample appears on the rising edge of the second clock phase.
// [R2] One pixel is delivered per two-phase clock period.
// [R3] Start pulse begins a scan addressing pixels in order from the first.
// [R4] Controller sets exposure by spacing of start pulses.
// [R5] While line reset is high, video holds the reset level.
// [R6] Active-low scan_done_n pulse follows the last pixel on phase two timing.
// [R7] Controller never drives both clock phases high together.
// [R8] Controller keeps each phase high at least 200 ns.
// [R9] Start high at least 200 ns, overlapping phase two once.
// [R10] Line reset rises during phase two high, falls during phase two low.
// [R11] Bench counts phase two periods and uses scan_done_n to confirm frame end.
`timescale 1ns/1ps
`default_nettype none
`include "lasr_defs.vh"
module lasr_scan_readout (
  input  wire                       sys_clk,
  input  wire                       rst_n,
  input  wire                       phase1_pin,
  input  wire                       phase2_pin,
  input  wire                       scan_start_pulse,
  input  wire                       line_reset_pin,
  input  wire [`LASR_SAMPLE_W-1:0]  light_level,
  output reg  [`LASR_SAMPLE_W-1:0]  video_out,
  output reg                        scan_done_n,
  output reg                        clock_fault
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SCAN = 3'b010;
  localparam [2:0] ST_LAST = 3'b100;
  localparam integer MIN_HIGH = `LASR_MIN_HIGH_CYC;

  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg  [1:0] prev_reg;
  reg  [7:0] ph1_cnt_reg;
  reg  [7:0] ph2_cnt_reg;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [`LASR_PIX_IDX_W:0]   pix_reg;
  reg  [`LASR_PIX_IDX_W:0]   pix_next;
  reg  [`LASR_PIX_IDX_W-1:0] acc_addr_reg;
  reg                        out_pending_reg;
  reg                        eos_pending_reg;
  wire [`LASR_SAMPLE_W-1:0]  mem_rd;

  wire ph1   = sync2_reg[0];
  wire ph2   = sync2_reg[1];
  wire start = sync2_reg[2];
  wire ph2_rise = ph2 & ~prev_reg[1];
  wire ph2_fall = ~ph2 & prev_reg[1];
  wire ph1_fall = ~ph1 & prev_reg[0];
  wire short_pulse = (ph1_fall && ({24'h00_0000, ph1_cnt_reg} < MIN_HIGH)) ||
                     (ph2_fall && ({24'h00_0000, ph2_cnt_reg} < MIN_HIGH));

  // Two-stage synchronisers on all pins
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg  <= 2'h0;
    end else begin
      sync1_reg <= {scan_start_pulse, phase2_pin, phase1_pin};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg[1:0];
    end
  end

  reg rst_s1_reg;
  reg rst_s2_reg;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= line_reset_pin;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Shift register advance happens on phase two falling edge
  always @* begin
    state_next = state_reg;
    pix_next   = pix_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && ph2_fall) begin
          state_next = ST_SCAN; // R3
          pix_next   = {(`LASR_PIX_IDX_W+1){1'b0}};
        end
      end
      ST_SCAN: begin
        if (ph2_fall) begin
          if (pix_reg == `LASR_NUM_PIXELS - 11'h0_001) begin
            state_next = ST_LAST;
          end else begin
            pix_next = pix_reg + 11'h0_001; // R2
          end
        end
      end
      ST_LAST: begin
        if (ph2_fall) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Restart wins over any scan in progress
    if (start && ph2_fall && state_reg != ST_IDLE) begin
      state_next = ST_SCAN; // R3
      pix_next   = {(`LASR_PIX_IDX_W+1){1'b0}};
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      pix_reg   <= {(`LASR_PIX_IDX_W+1){1'b0}};
    end else begin
      state_reg <= state_next;
      pix_reg   <= pix_next;
    end
  end

  // Integrate light on every pixel round-robin, one per cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_addr_reg <= {`LASR_PIX_IDX_W{1'b0}};
    end else begin
      acc_addr_reg <= acc_addr_reg + {{(`LASR_PIX_IDX_W-1){1'b0}}, 1'b1};
    end
  end

  // Read port points at the addressed pixel; charge is the light level
  lasr_pixel_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (rst_n),
    .wr_addr (acc_addr_reg),
    .wr_data (light_level),
    .rd_addr (pix_reg[`LASR_PIX_IDX_W-1:0]),
    .rd_data (mem_rd)
  );

  // Video update one cycle after the phase two rise, once read data settles
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      video_out       <= `LASR_RESET_LEVEL;
      out_pending_reg <= 1'b0;
    end else begin
      out_pending_reg <= ph2_rise && state_reg == ST_SCAN;
      if (rst_s2_reg) begin
        video_out <= `LASR_RESET_LEVEL; // R5
      end else if (out_pending_reg) begin
        video_out <= mem_rd; // R1
      end
    end
  end

  // Scan_done_n low for one phase two high after the last pixel
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      scan_done_n     <= 1'b1;
      eos_pending_reg <= 1'b0;
    end else begin
      if (state_reg == ST_SCAN && state_next == ST_LAST) begin
        eos_pending_reg <= 1'b1;
      end else if (ph2_rise) begin
        eos_pending_reg <= 1'b0;
      end
      if (ph2_rise && eos_pending_reg) begin
        scan_done_n <= 1'b0; // R6
      end else if (ph2_fall) begin
        scan_done_n <= 1'b1;
      end
    end
  end

  // High-time counters, saturating so a parked phase cannot wrap
  // Measured after synchronisation, so a width reads to within one cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ph1_cnt_reg <= 8'h00;
    end else if (!ph1) begin
      ph1_cnt_reg <= 8'h00;
    end else if (ph1_cnt_reg != 8'hff) begin
      ph1_cnt_reg <= ph1_cnt_reg + 8'h01;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ph2_cnt_reg <= 8'h00;
    end else if (!ph2) begin
      ph2_cnt_reg <= 8'h00;
    end else if (ph2_cnt_reg != 8'hff) begin
      ph2_cnt_reg <= ph2_cnt_reg + 8'h01;
    end
  end

  // Sticky flag for overlapping or short phases, cleared only by reset
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_fault <= 1'b0;
    end else if (short_pulse) begin
      clock_fault <= 1'b1; // R8
    end else if (ph1 && ph2) begin
      clock_fault <= 1'b1; // R7
    end
  end
endmodule
`default_nettype wire

// [lasr_scan_readout_properties.sv]
// Port checker for the scan readout block
`timescale 1ns/1ps
`default_nettype none
`include "lasr_defs.vh"
module lasr_props (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        phase2_pin,
  input wire logic        scan_start_pulse,
  input wire logic        line_reset_pin,
  input wire logic [11:0] video_out,
  input wire logic        scan_done_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_VID_PH2: assert property ($changed(video_out) && video_out != 12'h0_800 |-> phase2_pin)
    else $error("video moved off phase two");
  AST_ONE_PIX: assert property ($rose(phase2_pin) ##6 1 |-> $stable(video_out)[*5])
    else $error("video moved twice");
  AST_START: assert property ($fell(scan_start_pulse) |-> ##4 scan_done_n[*8])
    else $error("done soon after start");
  AST_RST_LVL: assert property (line_reset_pin[*5] |-> video_out == 12'h0_800)
    else $error("video not at reset level");
  AST_DONE_PH2: assert property ($fell(scan_done_n) |-> phase2_pin)
    else $error("done off phase two");
  AST_DONE_LEN: assert property ($fell(scan_done_n) |=> !scan_done_n[*8])
    else $error("done pulse short");
  cover property ($fell(scan_done_n));
  cover property ($rose(line_reset_pin));
  cover property ($fell(scan_start_pulse));
endmodule
`default_nettype wire

// [lasr_ctrl_model.sv]
// Timing controller model driving phases, start and line reset
`timescale 1ns/1ps
`default_nettype none
module lasr_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic start_req,
  output var logic  phase1_pin,
  output var logic  phase2_pin,
  output var logic  scan_start_pulse,
  output var logic  line_reset_pin
);
  initial begin
    {phase1_pin, phase2_pin, scan_start_pulse, line_reset_pin} = 4'h0;
    wait (rst_n === 1'b1);
    forever begin
      repeat (2) @(posedge sys_clk);
      #1 scan_start_pulse = start_req;
      phase1_pin = 1'b1;
      repeat (20) @(posedge sys_clk);
      #1 phase1_pin = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 phase2_pin = 1'b1;
      repeat (12) @(posedge sys_clk);
      #1 line_reset_pin = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 phase2_pin = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 {scan_start_pulse, line_reset_pin} = 2'b00;
    end
  end
endmodule
`default_nettype wire

// [tb_linear_array_scan_readout.sv]
// Self-checking bench for the scan readout block
`timescale 1ns/1ps
`default_nettype none
`include "lasr_defs.vh"
module tb_linear_array_scan_readout;
  localparam logic [11:0] LIGHT = 12'h0_5a3;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic phase1_pin, phase2_pin, scan_start_pulse, line_reset_pin, scan_done_n, clock_fault;
  logic [11:0] video_out;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  lasr_ctrl_model ctl (.sys_clk, .rst_n, .start_req, .phase1_pin, .phase2_pin, .scan_start_pulse,
    .line_reset_pin);
  lasr_scan_readout dut (.sys_clk, .rst_n, .phase1_pin, .phase2_pin, .scan_start_pulse,
    .line_reset_pin, .light_level(LIGHT), .video_out, .scan_done_n, .clock_fault);
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A short limit leaves the scan running, so the next call restarts it
  task automatic scan(input int lim);
    int n;
    n = 0;
    start_req = 1'b1;
    @(negedge scan_start_pulse);
    start_req = 1'b0;
    while (scan_done_n === 1'b1 && n < lim) begin
      @(posedge phase2_pin);
      n++;
      repeat (8) @(posedge sys_clk);
      #1;
      if (scan_done_n === 1'b1) begin
        check("pixel", video_out, LIGHT);
        @(negedge phase2_pin);
        check("reset level", video_out, 12'h0_800);
      end
    end
    if (lim > 600) check("periods", 12'(n), 12'h0_201);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check("video", video_out, 12'h0_800);
    check("flags", {10'h0, scan_done_n, clock_fault}, 12'h0_002);
    // Let the pixel store fill past the 512 read pixels before reading
    repeat (600) @(posedge sys_clk);
    scan(1000);
    scan(100);
    scan(1000);
    check("fault", {11'h0, clock_fault}, 12'h0_000);
    give_verdict;
  end
endmodule
bind lasr_scan_readout lasr_props chk (.sys_clk, .rst_n, .phase2_pin, .scan_start_pulse,
  .line_reset_pin, .video_out, .scan_done_n);
`default_nettype wire
